// ---- common/ssr_params.svh ----
// Constants for the status reporting and card query block
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH
// Status byte bit positions
`define SSR_MAV_BIT 4
`define SSR_ESB_BIT 5
`define SSR_RQS_BIT 6
// Standard event bits that exist (bits 1 and 6 always read zero)
`define SSR_ESR_USED 8'hBD
// Event register after power up: power-on event set
`define SSR_ESR_RST 8'h80
`define SSR_ESE_RST 8'h00
`define SSR_SRE_RST 8'h00
// Error queue
`define SSR_ERRQ_DEPTH 4'h8
`define SSR_ERRQ_AW 3
// Cards and multiplexer inputs
`define SSR_CARDS 4
`define SSR_MUX_INPUTS 6
`define SSR_AUTO_CARD 3'h0
`define SSR_LAST_CARD 3'h4
// Matrix card bias input after card power-on
`define SSR_BIAS_PORT_MATRIX 4'hA
// Command-language version: year 1995, revision 0
`define SSR_VER_YEAR 16'h07CB
`define SSR_VER_REV 4'h0
// Model codes in identity answers
`define SSR_MODEL_NONE 2'h0
`define SSR_MODEL_MATRIX 2'h1
`define SSR_MODEL_MUX 2'h2
// ASCII characters for count text
`define SSR_CHAR_SPACE 8'h20
`define SSR_CHAR_ZERO 8'h30
`endif

// ---- common/ssr_pkg.sv ----
// Types shared by the status reporting and card query block
package ssr_pkg;
	typedef enum logic [1:0] {SSR_ANS_NONE, SSR_ANS_DESC, SSR_ANS_IDENT} ssr_ans_kind_e;
	typedef struct packed {
		logic [15:0] code;
		logic [7:0] msg;
	} ssr_err_s;
	typedef struct packed {
		logic describe;
		logic identity;
		logic power_on;
		logic all;
		logic [2:0] num;
	} ssr_card_req_s;
	typedef struct packed {
		logic present;
		logic init_ok;
		logic is_mux;
		logic [7:0] revision;
	} ssr_card_info_s;
	typedef struct packed {
		logic valid;
		ssr_ans_kind_e kind;
		logic refused;
		logic absent;
		logic [15:0] maker;
		logic [1:0] model;
		logic [7:0] zero_field;
		logic [7:0] revision;
		logic mux_auto;
		logic [95:0] mux_text;
	} ssr_card_ans_s;
	typedef struct packed {
		logic conn_free;
		logic break_before_make;
		logic bias_mode;
		logic couple_mode;
		logic [3:0] bias_port;
		logic [4:0] couple_ports;
		logic bias_enable_all;
	} ssr_card_cfg_s;
endpackage

// ---- logic/ssr_status.sv ----
// Status byte, service request, error queue and card query logic
`timescale 1ns/100ps
`include "ssr_params.svh"
module ssr_status #(
	parameter logic [15:0] MAKER_ID = 16'h5A5A // Arbitrary value
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic oq_nonempty,
	input wire logic [7:0] event_set,
	input wire logic esr_query,
	input wire logic ese_wr,
	input wire logic [7:0] ese_data,
	input wire logic sre_wr,
	input wire logic [7:0] sre_data,
	input wire logic serial_poll_call,
	input wire logic stb_query,
	input wire logic err_push,
	input wire ssr_pkg::ssr_err_s err_push_data,
	input wire logic err_query,
	input wire ssr_pkg::ssr_card_req_s card_req,
	input wire logic auto_config,
	input wire ssr_pkg::ssr_card_info_s card_info [`SSR_CARDS],
	input wire logic [35:0] mux_counts,
	input wire logic [3:0] cfg_wr,
	input wire ssr_pkg::ssr_card_cfg_s cfg_data,
	input wire logic version_query,
	output logic srq_q,
	output logic [7:0] service_status_summary_byte_q,
	output logic [7:0] poll_byte_q,
	output logic poll_valid_q,
	output logic [7:0] stb_byte_q,
	output logic stb_valid_q,
	output logic [7:0] esr_byte_q,
	output logic esr_valid_q,
	output ssr_pkg::ssr_err_s err_ans_q,
	output logic err_valid_q,
	output ssr_pkg::ssr_card_ans_s card_ans_q,
	output ssr_pkg::ssr_card_cfg_s card_cfg_q [`SSR_CARDS],
	output logic [3:0] card_open_all_q,
	output logic [19:0] version_q,
	output logic version_valid_q
);
	import ssr_pkg::*;

	// Two-character ASCII count, leading zero shown as space
	function automatic logic [15:0] count_text(input logic [5:0] n);
		logic [5:0] tens;
		logic [5:0] ones;
		tens = n / 6'h0A;
		ones = n % 6'h0A;
		count_text[15:8] = (tens == 6'h00) ? `SSR_CHAR_SPACE : `SSR_CHAR_ZERO + {2'h0, tens};
		count_text[7:0] = `SSR_CHAR_ZERO + {2'h0, ones};
	endfunction

	// Power-on settings of one card
	function automatic ssr_card_cfg_s pon_cfg(input logic is_mux);
		pon_cfg.conn_free = 1'b1;
		pon_cfg.break_before_make = 1'b1;
		pon_cfg.bias_mode = 1'b0;
		pon_cfg.couple_mode = 1'b0;
		pon_cfg.bias_port = is_mux ? 4'h0 : `SSR_BIAS_PORT_MATRIX;
		pon_cfg.couple_ports = 5'h00;
		pon_cfg.bias_enable_all = 1'b1;
	endfunction

	// Status group state
	logic [7:0] esr_q, esr_d, ese_q, ese_d, sre_q, sre_d;
	logic rqs_d, reason_prev_q;
	logic [7:0] summary, status_d;
	logic reason, event_summary_flag;

	always_comb
	begin
		event_summary_flag = |(esr_q & ese_q);
		summary = 8'h00;
		summary[`SSR_MAV_BIT] = oq_nonempty;
		summary[`SSR_ESB_BIT] = event_summary_flag;
		reason = |(summary & sre_q);
		// New reason sets, poll clears, set wins
		rqs_d = (reason & ~reason_prev_q) | (srq_q & ~serial_poll_call);
		status_d = summary;
		status_d[`SSR_RQS_BIT] = rqs_d;
		esr_d = (esr_q & ~{8{esr_query}}) | (event_set & `SSR_ESR_USED);
		ese_d = ese_wr ? ese_data : ese_q;
		sre_d = sre_wr ? sre_data : sre_q;
	end

	// Status group registers and byte answers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			esr_q <= `SSR_ESR_RST;
			ese_q <= `SSR_ESE_RST;
			sre_q <= `SSR_SRE_RST;
			srq_q <= 1'b0;
			reason_prev_q <= 1'b0;
			service_status_summary_byte_q <= 8'h00;
			poll_byte_q <= 8'h00;
			poll_valid_q <= 1'b0;
			stb_byte_q <= 8'h00;
			stb_valid_q <= 1'b0;
			esr_byte_q <= 8'h00;
			esr_valid_q <= 1'b0;
		end
		else
		begin
			esr_q <= esr_d;
			ese_q <= ese_d;
			sre_q <= sre_d;
			srq_q <= rqs_d;
			reason_prev_q <= reason;
			service_status_summary_byte_q <= status_d;
			// Poll and query both see request flag before its clear
			poll_byte_q <= summary | {1'b0, srq_q, 6'h00};
			poll_valid_q <= serial_poll_call;
			stb_byte_q <= summary | {1'b0, srq_q, 6'h00};
			stb_valid_q <= stb_query;
			esr_byte_q <= esr_q;
			esr_valid_q <= esr_query;
		end
	end

	// Error queue state
	ssr_err_s err_mem [`SSR_ERRQ_DEPTH];
	logic [`SSR_ERRQ_AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [3:0] err_cnt_q, err_cnt_d;
	logic do_push, do_pop;
	ssr_err_s err_ans_d;

	always_comb
	begin
		do_pop = err_query && (err_cnt_q != 4'h0);
		do_push = err_push && ((err_cnt_q != `SSR_ERRQ_DEPTH) || do_pop);
		wr_ptr_d = do_push ? wr_ptr_q + 3'h1 : wr_ptr_q;
		rd_ptr_d = do_pop ? rd_ptr_q + 3'h1 : rd_ptr_q;
		err_cnt_d = err_cnt_q + {3'h0, do_push} - {3'h0, do_pop};
		err_ans_d = do_pop ? err_mem[rd_ptr_q] : '0;
	end

	// Error queue registers; newest error dropped when full and not read in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			err_cnt_q <= 4'h0;
			err_ans_q <= '0;
			err_valid_q <= 1'b0;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			err_cnt_q <= err_cnt_d;
			err_ans_q <= err_query ? err_ans_d : err_ans_q;
			err_valid_q <= err_query;
		end
		if (do_push)
			err_mem[wr_ptr_q] <= err_push_data;
	end

	// Multiplexer count text, one field per input
	logic [95:0] mux_text;
	generate
		for (genvar g = 0; g < `SSR_MUX_INPUTS; g++)
		begin : g_text
			assign mux_text[95-16*g -: 16] = count_text(mux_counts[35-6*g -: 6]);
		end
	endgenerate

	// Card query and card configuration state
	logic accepted, absent;
	logic [1:0] slot;
	ssr_card_info_s info;
	ssr_card_ans_s card_ans_d;
	ssr_card_cfg_s card_cfg_d [`SSR_CARDS];
	logic [3:0] open_all_d;

	always_comb
	begin
		accepted = auto_config ? (card_req.num == `SSR_AUTO_CARD)
			: (card_req.num != 3'h0 && card_req.num <= `SSR_LAST_CARD);
		slot = auto_config ? 2'h0 : 2'(card_req.num - 3'h1);
		info = card_info[slot];
		absent = ~info.present | ~info.init_ok;
		card_ans_d = card_ans_q;
		card_ans_d.valid = card_req.describe | card_req.identity;
		if (card_req.describe | card_req.identity)
		begin
			card_ans_d.kind = card_req.describe ? SSR_ANS_DESC : SSR_ANS_IDENT;
			card_ans_d.refused = ~accepted;
			card_ans_d.absent = absent;
			card_ans_d.maker = absent ? 16'h0000 : MAKER_ID;
			card_ans_d.model = absent ? `SSR_MODEL_NONE
				: (info.is_mux ? `SSR_MODEL_MUX : `SSR_MODEL_MATRIX);
			card_ans_d.zero_field = 8'h00;
			card_ans_d.revision = absent ? 8'h00 : info.revision;
			card_ans_d.mux_auto = auto_config & info.is_mux & ~absent;
			card_ans_d.mux_text = mux_text;
		end
		for (int c = 0; c < `SSR_CARDS; c++)
		begin
			open_all_d[c] = card_req.power_on && (card_req.all || (accepted && slot == 2'(c)));
			if (open_all_d[c])
				card_cfg_d[c] = pon_cfg(card_info[c].is_mux);
			else if (cfg_wr[c])
				card_cfg_d[c] = cfg_data;
			else
				card_cfg_d[c] = card_cfg_q[c];
		end
	end

	// Card and version registers; open-all pulse tells the relay driver to open everything
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			card_ans_q <= '0;
			card_open_all_q <= 4'h0;
			version_q <= 20'h00000;
			version_valid_q <= 1'b0;
			for (int c = 0; c < `SSR_CARDS; c++)
				card_cfg_q[c] <= '0;
		end
		else
		begin
			card_ans_q <= card_ans_d;
			card_open_all_q <= open_all_d;
			version_q <= {`SSR_VER_YEAR, `SSR_VER_REV};
			version_valid_q <= version_query;
			for (int c = 0; c < `SSR_CARDS; c++)
				card_cfg_q[c] <= card_cfg_d[c];
		end
	end

	// Checks
	sequence poll_clear_s;
		serial_poll_call && !(reason && !reason_prev_q);
	endsequence
	sequence new_reason_s;
		reason && !reason_prev_q;
	endsequence

	mav_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		##1 service_status_summary_byte_q[`SSR_MAV_BIT] == $past(oq_nonempty))
		else $error("message bit does not follow queue");
	esb_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		##1 service_status_summary_byte_q[`SSR_ESB_BIT] == $past(|(esr_q & ese_q)))
		else $error("event summary bit wrong");
	srq_raise_a: assert property (@(posedge clk) disable iff (sys_rst)
		new_reason_s |=> srq_q && service_status_summary_byte_q[`SSR_RQS_BIT])
		else $error("request not raised");
	poll_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		srq_q ##0 poll_clear_s |=> !srq_q ##0 (poll_valid_q && poll_byte_q[`SSR_RQS_BIT]))
		else $error("poll did not clear request");
	rqs_equal_a: assert property (@(posedge clk) disable iff (sys_rst)
		stb_valid_q |-> stb_byte_q[`SSR_RQS_BIT] == $past(srq_q))
		else $error("query bit 6 differs from request flag");
	err_empty_a: assert property (@(posedge clk) disable iff (sys_rst)
		err_query && err_cnt_q == 4'h0 |=> err_valid_q && err_ans_q == '0)
		else $error("empty error queue answer wrong");
	card_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
		card_req.identity && auto_config && card_req.num != 3'h0 |=> card_ans_q.refused)
		else $error("wrong card number accepted");
	cpon_state_a: assert property (@(posedge clk) disable iff (sys_rst)
		card_req.power_on && card_req.all |=>
		card_open_all_q == 4'hF && card_cfg_q[0].conn_free && card_cfg_q[0].bias_enable_all
		&& !card_cfg_q[0].couple_mode && card_cfg_q[0].bias_port
		== ($past(card_info[0].is_mux) ? 4'h0 : `SSR_BIAS_PORT_MATRIX))
		else $error("card power-on state wrong");
endmodule

// ---- verif/ssr_ctrl_model.sv ----
// Bus controller model that serial polls after a service request
`timescale 1ns/100ps
module ssr_ctrl_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic srq_q,
	input wire logic [3:0] delay,
	output logic serial_poll_call
);
	logic [3:0] wait_q;
	logic busy_q;
	// One poll per request, after the chosen delay
	always_ff @(posedge clk)
	begin
		serial_poll_call <= 1'b0;
		if (sys_rst || !srq_q)
		begin
			wait_q <= 4'h0;
			busy_q <= 1'b0;
		end
		else if (!busy_q && wait_q == delay)
		begin
			serial_poll_call <= 1'b1;
			busy_q <= 1'b1;
		end
		else if (!busy_q)
			wait_q <= wait_q + 4'h1;
	end
endmodule

// ---- verif/tb_ssr_status.sv ----
// Self-checking bench for the status reporting and card query block
`timescale 1ns/100ps
`include "ssr_params.svh"
module tb_ssr_status;
	import ssr_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, oq_nonempty = 1'b0, esr_query = 1'b0, ese_wr = 1'b0;
	logic sre_wr = 1'b0, stb_query = 1'b0, err_push = 1'b0, err_query = 1'b0;
	logic auto_config = 1'b0, version_query = 1'b0, serial_poll_call;
	logic [7:0] event_set = 8'h00, ese_data = 8'h00, sre_data = 8'h00;
	logic [3:0] cfg_wr = 4'h0, delay = 4'h0, card_open_all_q;
	logic [35:0] mux_counts = 36'h0;
	ssr_err_s err_push_data = '0, err_ans_q, pushed [3];
	ssr_card_req_s card_req = '0;
	ssr_card_info_s card_info [`SSR_CARDS];
	ssr_card_cfg_s cfg_data = '1, card_cfg_q [`SSR_CARDS];
	ssr_card_ans_s card_ans_q;
	logic srq_q, poll_valid_q, stb_valid_q, esr_valid_q, err_valid_q, version_valid_q;
	logic [7:0] service_status_summary_byte_q, poll_byte_q, stb_byte_q, esr_byte_q;
	logic [7:0] ev, en, exp_esr;
	logic [19:0] version_q;
	logic [95:0] exp_t;
	int n_errors = 0, check_count = 0, seed, i, k;
	localparam logic [15:0] MAKER = 16'h1234; // Arbitrary value
	// Free-running clock
	always #10 clk = ~clk;
	ssr_status #(.MAKER_ID(MAKER)) dut_u (
		.clk, .sys_rst, .oq_nonempty, .event_set, .esr_query, .ese_wr, .ese_data, .sre_wr,
		.sre_data, .serial_poll_call, .stb_query, .err_push, .err_push_data, .err_query,
		.card_req, .auto_config, .card_info, .mux_counts, .cfg_wr, .cfg_data, .version_query,
		.srq_q, .service_status_summary_byte_q, .poll_byte_q, .poll_valid_q, .stb_byte_q,
		.stb_valid_q, .esr_byte_q, .esr_valid_q, .err_ans_q, .err_valid_q, .card_ans_q,
		.card_cfg_q, .card_open_all_q, .version_q, .version_valid_q
	);
	ssr_ctrl_model ctrl_u (.clk, .sys_rst, .srq_q, .delay, .serial_poll_call);
	// Expected two-character count text
	function automatic logic [15:0] two_ch(input logic [5:0] v);
		two_ch[15:8] = (v < 6'h0A) ? 8'h20 : 8'h30 + 8'(v / 6'h0A);
		two_ch[7:0] = 8'h30 + 8'(v % 6'h0A);
	endfunction
	// Expected identity: absent, maker, model, zero, revision
	function automatic logic [34:0] id_exp(input ssr_card_info_s c);
		if (!(c.present && c.init_ok))
			return {1'b1, 34'h0};
		return {1'b0, MAKER, c.is_mux ? 2'h2 : 2'h1, 8'h00, c.revision};
	endfunction
	// Expected card settings after power-on
	function automatic ssr_card_cfg_s pon_cfg(input logic is_mux);
		return {1'b1, 1'b1, 1'b0, 1'b0, is_mux ? 4'h0 : 4'hA, 5'h00, 1'b1};
	endfunction
	task automatic chk_val(input logic [95:0] got, input logic [95:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk_val({95'h0, got}, {95'h0, exp});
	endtask
	// One-cycle strobes; returns once the answer has settled
	task automatic pulse(input logic [6:0] p, input logic [7:0] e, input ssr_card_req_s c);
		@(posedge clk);
		{esr_query, ese_wr, sre_wr, stb_query, err_push, err_query, version_query} <= p;
		event_set <= e;
		card_req <= c;
		@(posedge clk);
		{esr_query, ese_wr, sre_wr, stb_query, err_push, err_query, version_query} <= 7'h00;
		event_set <= 8'h00;
		card_req <= '0;
		#1;
	endtask
	task automatic final_report();
		$display("Checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		seed = 42;
		card_info = '{'{1'b1, 1'b1, 1'b1, 8'h21}, '{1'b1, 1'b1, 1'b0, 8'h37},
			'{1'b0, 1'b0, 1'b0, 8'h00}, '{1'b1, 1'b0, 1'b0, 8'h44}};
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk_val(service_status_summary_byte_q, 8'h00);
		sre_data <= 8'h10;
		pulse(7'h10, 8'h00, '0);
		// Message request, polled promptly then slowly
		for (k = 0; k < 2; k++)
		begin
			delay <= k ? 4'h7 : 4'h0;
			@(posedge clk);
			oq_nonempty <= 1'b1;
			repeat (2) @(posedge clk);
			#1;
			chk_flag(service_status_summary_byte_q[4], 1'b1);
			chk_flag(srq_q, 1'b1);
			// Query while the request still stands, before the slow poll
			if (k)
			begin
				pulse(7'h08, 8'h00, '0);
				chk_val(stb_byte_q, 8'h50);
			end
			for (i = 0; i < 30 && poll_valid_q !== 1'b1; i++)
				@(posedge clk) #1;
			chk_flag(poll_valid_q, 1'b1);
			chk_val(poll_byte_q, 8'h50);
			repeat (2) @(posedge clk);
			#1;
			chk_flag(srq_q, 1'b0);
			chk_flag(service_status_summary_byte_q[6], 1'b0);
			pulse(7'h08, 8'h00, '0);
			chk_flag(stb_valid_q, 1'b1);
			chk_val(stb_byte_q[5:0], 6'h10);
			chk_flag(stb_byte_q[6], 1'b0);
			oq_nonempty <= 1'b0;
		end
		// Event summary: power-on event, then random events and masks
		exp_esr = 8'h80;
		for (k = 0; k < 6; k++)
		begin
			en = k ? 8'($random(seed)) : 8'h80;
			ev = k ? 8'($random(seed)) : 8'h00;
			ese_data <= en;
			pulse(7'h20, ev, '0);
			exp_esr = exp_esr | (ev & `SSR_ESR_USED);
			repeat (2) @(posedge clk);
			#1;
			chk_flag(service_status_summary_byte_q[5], |(exp_esr & en));
			chk_flag(srq_q, 1'b0);
			pulse(7'h40, 8'h00, '0);
			chk_flag(esr_valid_q, 1'b1);
			chk_val(esr_byte_q, exp_esr);
			exp_esr = 8'h00;
		end
		// Error queue: empty answer, then oldest first
		pulse(7'h02, 8'h00, '0);
		chk_val(err_ans_q, 24'h0);
		for (k = 0; k < 3; k++)
		begin
			pushed[k] = 24'($random(seed));
			err_push_data <= pushed[k];
			pulse(7'h04, 8'h00, '0);
		end
		for (k = 0; k < 4; k++)
		begin
			pulse(7'h02, 8'h00, '0);
			chk_flag(err_valid_q, 1'b1);
			chk_val(err_ans_q, k < 3 ? pushed[k] : 24'h0);
		end
		pulse(7'h01, 8'h00, '0);
		chk_flag(version_valid_q, 1'b1);
		chk_val(version_q, {`SSR_VER_YEAR, `SSR_VER_REV});
		// Disturb settings, power-on one card, then all
		cfg_wr <= 4'hF;
		@(posedge clk);
		cfg_wr <= 4'h0;
		pulse(7'h00, 8'h00, 7'h12);
		chk_val(card_open_all_q, 4'h2);
		chk_val(card_cfg_q[1], pon_cfg(1'b0));
		chk_val(card_cfg_q[0], 14'h3FFF);
		pulse(7'h00, 8'h00, 7'h18);
		chk_val(card_open_all_q, 4'hF);
		for (k = 0; k < 4; k++)
			chk_val(card_cfg_q[k], pon_cfg(card_info[k].is_mux));
		// Identity over valid and invalid numbers, description over valid ones
		for (k = 0; k < 6; k++)
		begin
			pulse(7'h00, 8'h00, 7'h20 | 7'(k));
			chk_val({card_ans_q.valid, card_ans_q.kind}, {1'b1, SSR_ANS_IDENT});
			chk_flag(card_ans_q.refused, k == 0 || k == 5);
			if (k inside {[1:4]})
			begin
				chk_val({card_ans_q.absent, card_ans_q.maker, card_ans_q.model,
					card_ans_q.zero_field, card_ans_q.revision}, id_exp(card_info[k - 1]));
				pulse(7'h00, 8'h00, 7'h40 | 7'(k));
				chk_val({card_ans_q.valid, card_ans_q.kind}, {1'b1, SSR_ANS_DESC});
				chk_flag(card_ans_q.absent, k > 2);
			end
		end
		// Auto mode multiplexer text, one count zero
		auto_config <= 1'b1;
		mux_counts <= {$random(seed), 4'h0} & 36'hFFF03FFFF;
		pulse(7'h00, 8'h00, 7'h40);
		for (k = 0; k < 6; k++)
			exp_t[95 - 16 * k -: 16] = two_ch(mux_counts[35 - 6 * k -: 6]);
		chk_flag(card_ans_q.mux_auto, 1'b1);
		chk_val(card_ans_q.mux_text, exp_t);
		pulse(7'h00, 8'h00, 7'h21);
		chk_flag(card_ans_q.refused, 1'b1);
		final_report();
	end
	// Watchdog on a hung run
	initial
	begin
		#200000;
		n_errors++;
		final_report();
	end
endmodule
